// file: hw/uim_top.sv
// top of the usb host interrupt mask pair: ahb-lite slave and mask
// assumes one ahb-lite master, word transfers, flags from same clock
//
// Operation
// R1 - set-port at 0x10, clear-port at 0x14
// R2 - bit 31 gates all event interrupts
// R3 - bit 30 enables ownership change interrupt
// R4 - bit 6 enables root port status change
// R5 - bit 5 enables frame count overflow
// R6 - bit 4 enables fatal system error
// R7 - bit 3 enables resume detect interrupt
// R8 - bit 2 enables frame start interrupt
// R9 - bit 1 enables done-list write-back interrupt
// R10 - bit 0 enables scheduling overrun interrupt
// R11 - software writes zero to reserved bits
// R12 - clear-port one clears mask bit
// R13 - clear-port zero leaves mask bit
// R14 - clear-port read returns current mask
// R15 - clear-port is one 32-bit word
// R16 - any reset closes the master gate
// R17 - irq needs flag, mask and gate
// R18 - set-port one sets, read returns mask
// R19 - reserved mask bits hold and read zero
`timescale 1ns/10ps
module uim_top
	import uim_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave inputs
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// ahb-lite slave outputs
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// host controller side
	input wire logic soft_reset,
	input wire logic [31:0] event_flags,
	// interrupt and mask view
	output logic irq,
	output logic [31:0] mask_out
);

	// bus phase tracker
	typedef enum logic [2:0] {
		UIM_ST_IDLE = 3'b001,
		UIM_ST_WRITE = 3'b010,
		UIM_ST_READ = 3'b100
	} uim_state_e;

	uim_state_e state_q;
	uim_state_e state_d;
	uim_req_s req_q;
	uim_req_s req_d;
	uim_mask_wr_s mask_wr;
	logic take;
	logic [UIM_DW-1:0] mask_q;
	logic [UIM_DW-1:0] mask_d;
	logic [UIM_DW-1:0] pending;
	logic [UIM_DW-1:0] rd_word;
	logic [31:0] hrdata_q;
	logic [31:0] mask_out_q;
	logic hreadyout_q;
	logic hresp_q;
	logic irq_int;
	logic soft_reset_q;

	// hsize is not decoded: every transfer is taken as a whole word
	// address phase is taken when selected, nonseq and bus ready
	assign take = hsel && hready && (htrans == UIM_HTRANS_NONSEQ);

	// capture of the address phase
	always_comb
	begin
		req_d = req_q;
		if (hready)
		begin
			req_d.valid = take;
			req_d.write = hwrite;
			req_d.addr = haddr[UIM_AW-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			req_q <= '0;
		else
			req_q <= req_d;
	end

	// phase tracking state machine
	always_comb
	begin
		state_d = UIM_ST_IDLE;
		if (take && hwrite)
			state_d = UIM_ST_WRITE;
		else if (take)
			state_d = UIM_ST_READ;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_q <= UIM_ST_IDLE;
		else
			state_q <= state_d;
	end

	// write strobes in the data phase, hwdata valid now
	always_comb
	begin
		mask_wr.set_en = 1'b0;
		mask_wr.clear_en = 1'b0;
		mask_wr.data = hwdata;
		unique case (state_q)
			UIM_ST_WRITE:
			begin
				// whole word write, all four lanes
				mask_wr.set_en = req_q.valid && req_q.write &&
					(req_q.addr == UIM_OFS_ENABLE_SET); // R1 R18
				mask_wr.clear_en = req_q.valid && req_q.write &&
					(req_q.addr == UIM_OFS_ENABLE_CLEAR); // R1 R15
			end
			UIM_ST_IDLE, UIM_ST_READ:
			begin
				mask_wr.set_en = 1'b0;
				mask_wr.clear_en = 1'b0;
			end
		endcase
	end

	// software reset pulse, same clock, registered once
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			soft_reset_q <= 1'b0;
		else
			soft_reset_q <= soft_reset;
	end

	// mask storage
	uim_mask_reg u_mask (
		.hclk(hclk),
		.hresetn(hresetn),
		.soft_reset(soft_reset_q),
		.wr(mask_wr),
		.mask_q(mask_q),
		.mask_d(mask_d)
	);

	// interrupt gating
	uim_irq_gate u_gate (
		.hclk(hclk),
		.hresetn(hresetn),
		.event_flags(event_flags),
		.mask(mask_q),
		.pending(pending),
		.irq_q(irq_int)
	);

	// read mux; mask_d forwards a write in its data phase
	always_comb
	begin
		rd_word = UIM_ZERO_WORD;
		unique case (haddr[UIM_AW-1:0])
			UIM_OFS_ENABLE_SET:
				rd_word = mask_d; // R18
			UIM_OFS_ENABLE_CLEAR:
				rd_word = mask_d; // R14
			UIM_OFS_PENDING:
				rd_word = pending;
			UIM_OFS_EVENT_VIEW:
				rd_word = event_flags & UIM_EVENT_BITS;
			default:
				rd_word = UIM_ZERO_WORD;
		endcase
	end

	// read data loaded at the end of the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= UIM_ZERO_WORD;
		else if (take && !hwrite)
			hrdata_q <= rd_word;
	end

	// zero wait state, always okay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout_q <= 1'b1;
			hresp_q <= UIM_HRESP_OKAY;
		end
		else
		begin
			hreadyout_q <= 1'b1;
			hresp_q <= UIM_HRESP_OKAY;
		end
	end

	// mask view for the rest of the host controller
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mask_out_q <= UIM_MASK_RESET;
		else
			mask_out_q <= mask_q;
	end

	// outputs straight from flops
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign irq = irq_int;
	assign mask_out = mask_out_q;

endmodule // uim_top

// file: hw/uim_pkg.sv
// package for the usb host interrupt mask pair block
// assumes a 32-bit ahb-lite register bus and one 100 MHz clock
package uim_pkg;

	// data width of the bus and of the mask
	localparam int unsigned UIM_DW = 32;
	localparam int unsigned UIM_AW = 8;

	// register byte offsets
	localparam logic [7:0] UIM_OFS_ENABLE_SET = 8'h10;
	localparam logic [7:0] UIM_OFS_ENABLE_CLEAR = 8'h14;
	localparam logic [7:0] UIM_OFS_PENDING = 8'h18;
	localparam logic [7:0] UIM_OFS_EVENT_VIEW = 8'h1C;

	// mask field positions
	localparam int unsigned UIM_BIT_MASTER_IRQ_GATE = 31;
	localparam int unsigned UIM_BIT_OWNERSHIP_CHANGE = 30;
	localparam int unsigned UIM_BIT_ROOT_PORT_STATUS_CHANGE = 6;
	localparam int unsigned UIM_BIT_FRAME_COUNT_OVERFLOW = 5;
	localparam int unsigned UIM_BIT_FATAL_SYSTEM_ERROR = 4;
	localparam int unsigned UIM_BIT_RESUME_DETECT = 3;
	localparam int unsigned UIM_BIT_FRAME_START = 2;
	localparam int unsigned UIM_BIT_DONE_LIST_WRITEBACK = 1;
	localparam int unsigned UIM_BIT_SCHED_OVERRUN = 0;

	// implemented mask bits; positions 29 to 7 are reserved
	localparam logic [31:0] UIM_IMPL_BITS = 32'hC000_007F;
	// event bits that may request an interrupt (all but the gate)
	localparam logic [31:0] UIM_EVENT_BITS = 32'h4000_007F;
	localparam logic [31:0] UIM_MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] UIM_ZERO_WORD = 32'h0000_0000;

	// ahb transfer type code for a nonsequential transfer
	localparam logic [1:0] UIM_HTRANS_NONSEQ = 2'h2;
	localparam logic UIM_HRESP_OKAY = 1'h0;

	// one captured address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [UIM_AW-1:0] addr;
	} uim_req_s;

	// write strobes towards the mask storage
	typedef struct packed {
		logic set_en;
		logic clear_en;
		logic [UIM_DW-1:0] data;
	} uim_mask_wr_s;

endpackage

// file: hw/uim_mask_reg.sv
// enable mask storage, one generate slice per bit
// assumes strobes and data come from the bus slave on the same clock
`timescale 1ns/10ps
module uim_mask_reg
	import uim_pkg::*;
(
	// clock and resets
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic soft_reset,
	// write strobes
	input wire uim_mask_wr_s wr,
	// mask value now and next
	output logic [UIM_DW-1:0] mask_q,
	output logic [UIM_DW-1:0] mask_d
);

	genvar i;
	generate
		for (i = 0; i < UIM_DW; i = i + 1)
		begin : g_bit
			if (UIM_IMPL_BITS[i])
			begin : g_impl
				// ones set, ones clear, zeros keep
				always_comb
				begin
					mask_d[i] = mask_q[i];
					if (soft_reset)
						mask_d[i] = UIM_MASK_RESET[i]; // R16
					else if (wr.set_en && wr.data[i])
						mask_d[i] = 1'b1; // R18
					else if (wr.clear_en && wr.data[i])
						mask_d[i] = 1'b0; // R12
				end
				// hardware reset leaves the gate closed
				always_ff @(posedge hclk or negedge hresetn)
				begin
					if (!hresetn)
						mask_q[i] <= UIM_MASK_RESET[i]; // R16
					else
						mask_q[i] <= mask_d[i]; // R13
				end
			end
			else
			begin : g_rsvd
				// reserved bit ignores written data
				assign mask_d[i] = 1'b0; // R19
				assign mask_q[i] = 1'b0; // R19
			end
		end
	endgenerate

endmodule // uim_mask_reg

// file: hw/uim_irq_gate.sv
// interrupt request gate: flag and mask bit and master gate
// assumes event flags are levels from logic on the same clock
`timescale 1ns/10ps
module uim_irq_gate
	import uim_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// flags and mask
	input wire logic [UIM_DW-1:0] event_flags,
	input wire logic [UIM_DW-1:0] mask,
	// gated results
	output logic [UIM_DW-1:0] pending,
	output logic irq_q
);

	// per-event enable, the gate bit itself excluded
	assign pending = event_flags & mask & UIM_EVENT_BITS; // R3 R4 R5 R6 R7 R8 R9 R10

	// request only when the master gate is open
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_q <= 1'b0;
		else
			irq_q <= mask[UIM_BIT_MASTER_IRQ_GATE] && (|pending); // R2 R17
	end

endmodule // uim_irq_gate

// file: verif/uim_checker.sv
// assertions on the mask pair top ports
// assumes one clock and a zero wait state bus
`timescale 1ns/10ps
module uim_checker
	import uim_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus side
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// host side
	input wire logic soft_reset,
	input wire logic [31:0] event_flags,
	input wire logic irq,
	input wire logic [31:0] mask_out
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// taken address phases
	wire tk = hsel && hready && htrans == UIM_HTRANS_NONSEQ;
	wire [7:0] ofs = haddr[7:0];
	wire wset = tk && hwrite && ofs == UIM_OFS_ENABLE_SET && !soft_reset;
	wire wclr = tk && hwrite && ofs == UIM_OFS_ENABLE_CLEAR && !soft_reset;
	wire rmsk = tk && !hwrite && ofs[7:3] == 5'h02 && !ofs[1];
	a_ready_okay: assert property (hreadyout && hresp == UIM_HRESP_OKAY)
		else $error("bus answer not ready");
	a_gate_closed: assert property (!mask_out[31] |-> !irq)
		else $error("irq with gate closed");
	a_irq_cause: assert property (irq == (mask_out[31] &&
		|($past(event_flags) & mask_out & UIM_EVENT_BITS)))
		else $error("irq not flag and mask");
	a_set_write: assert property (wset |-> ##3 mask_out ==
		($past(mask_out) | ($past(hwdata, 2) & UIM_IMPL_BITS)))
		else $error("set port write wrong");
	a_clear_write: assert property (wclr |-> ##3 mask_out ==
		($past(mask_out) & ~$past(hwdata, 2)))
		else $error("clear port write wrong");
	a_read_mask: assert property (rmsk |-> ##2 $past(hrdata) == mask_out)
		else $error("read not current mask");
	a_soft_clear: assert property (soft_reset |-> ##3 mask_out == 32'h0)
		else $error("soft reset kept mask");
	a_reserved_zero: assert property
		(((mask_out | hrdata) & ~UIM_IMPL_BITS) == UIM_ZERO_WORD)
		else $error("reserved bit set");
	// main scenarios
	cover property (wset);
	cover property (wclr);
	cover property ($rose(irq));
endmodule // uim_checker

bind uim_top uim_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .soft_reset,
	.event_flags, .irq, .mask_out);

// file: verif/tb.sv
// bench for the mask pair over ahb-lite
// assumes hreadyout is fed back as hready
`timescale 1ns/10ps
module tb
	import uim_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hwrite = 1'b0;
	logic soft_reset = 1'b0;
	logic hsel = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, event_flags = 32'h0;
	logic [31:0] hrdata, mask_out;
	logic hreadyout, hresp, irq;
	int fails = 0;
	int comparisons = 0;
	int unsigned ev [8] = '{30, 6, 5, 4, 3, 2, 1, 0};
	uim_top u_uim_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .soft_reset, .event_flags, .irq, .mask_out);
	// 100 MHz clock
	initial
	begin
		forever #5 hclk = ~hclk;
	end
	// counts and reports one comparison
	task automatic chk(input string n, input logic [31:0] e, s);
		comparisons++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// one word transfer, read data compared
	task automatic acc(input logic w, input logic [31:0] a, d, e);
		haddr <= a;
		hwrite <= w;
		htrans <= UIM_HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		if (!w)
			chk("hrdata", e, hrdata);
	endtask
	// irq two edges after the mask update
	task automatic irq_is(input logic e);
		repeat (2) @(posedge hclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// test sequence
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		acc(1'b0, 32'h10, 32'h0, UIM_MASK_RESET);
		acc(1'b0, 32'h14, 32'h0, UIM_MASK_RESET);
		$display("test reset done");
		foreach (ev[i])
		begin
			event_flags <= 32'h1 << ev[i];
			acc(1'b1, 32'h10, 32'h8000_0000 | (32'h1 << ev[i]), 32'h0);
			irq_is(1'b1);
			acc(1'b1, 32'h14, 32'h1 << ev[i], 32'h0);
			irq_is(1'b0);
		end
		event_flags <= UIM_EVENT_BITS;
		acc(1'b1, 32'h10, UIM_EVENT_BITS, 32'h0);
		irq_is(1'b1);
		acc(1'b1, 32'h14, 32'h8000_0000, 32'h0);
		irq_is(1'b0);
		acc(1'b0, 32'h14, 32'h0, UIM_EVENT_BITS);
		$display("test gate done");
		acc(1'b1, 32'h14, 32'h5, 32'h0);
		acc(1'b0, 32'h10, 32'h0, UIM_EVENT_BITS & ~32'h5);
		event_flags <= 32'h0000_0033;
		acc(1'b0, 32'h18, 32'h0, 32'h0000_0032);
		acc(1'b0, 32'h1C, 32'h0, 32'h0000_0033);
		hsel <= 1'b0;
		acc(1'b1, 32'h14, UIM_IMPL_BITS, 32'h0);
		hsel <= 1'b1;
		acc(1'b0, 32'h10, 32'h0, UIM_EVENT_BITS & ~32'h5);
		acc(1'b1, 32'h10, 32'hFFFF_FFFF, 32'h0);
		acc(1'b0, 32'h14, 32'h0, UIM_IMPL_BITS);
		acc(1'b0, 32'h40, 32'h0, UIM_ZERO_WORD);
		$display("test access done");
		soft_reset <= 1'b1;
		@(posedge hclk);
		soft_reset <= 1'b0;
		repeat (2) @(posedge hclk);
		acc(1'b0, 32'h10, 32'h0, UIM_MASK_RESET);
		irq_is(1'b0);
		$display("test soft reset done");
		acc(1'b1, 32'h10, UIM_IMPL_BITS, 32'h0);
		irq_is(1'b1);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		acc(1'b0, 32'h14, 32'h0, UIM_MASK_RESET);
		irq_is(1'b0);
		$display("test hard reset done");
		end_of_test();
	end
	// watchdog
	initial
	begin
		#20us;
		fails++;
		end_of_test();
	end
endmodule // tb
